// [hw/oam_pkg.sv]
/*
  Constants for the own-address match block: register indices on the plain
  register port, field positions, reset values and the address-compare helper.
  Assumes a 4-bit register index and 16-bit register data.
*/
`default_nettype none

package oam_pkg;

  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;
  localparam int unsigned AFW = 10;
  localparam int unsigned NSLOT = 3;

  // Register indices
  localparam logic [AW-1:0] OFS_SLOT0  = 4'h0;
  localparam logic [AW-1:0] OFS_SLOT1  = 4'h1;
  localparam logic [AW-1:0] OFS_SLOT2  = 4'h2;
  localparam logic [AW-1:0] OFS_MASK   = 4'h3;
  localparam logic [AW-1:0] OFS_RXADDR = 4'h4;
  localparam logic [AW-1:0] OFS_STAT   = 4'h5;
  localparam logic [AW-1:0] OFS_CTRL   = 4'h6;

  // Field positions
  localparam int unsigned GCEN_BIT    = 15;
  localparam int unsigned OAEN_BIT    = 10;
  localparam int unsigned ADDR_MSB    = 9;
  localparam int unsigned ADDR7_MSB   = 6;
  localparam int unsigned STAT_GC_BIT = 5;
  localparam int unsigned CTRL_HOLD_BIT  = 0;
  localparam int unsigned CTRL_MODE_BIT  = 1;

  // Reset values
  localparam logic [AFW-1:0] SLOT_ADDR_RST = 10'h000;
  localparam logic [AFW-1:0] MASK_RST      = 10'h3ff;
  localparam logic           HOLD_RST      = 1'b1;
  localparam logic           MODE_RST      = 1'b0;

  // Compare widths and the general call address
  localparam logic [AFW-1:0] WIDTH7_MASK  = 10'h07f;
  localparam logic [AFW-1:0] WIDTH10_MASK = 10'h3ff;
  localparam logic [AFW-1:0] GC_ADDR      = 10'h000;

  function automatic logic addr_hit(input logic [AFW-1:0] rx,
                                    input logic [AFW-1:0] own,
                                    input logic [AFW-1:0] mask,
                                    input logic           mode10);
    logic [AFW-1:0] width_m;
    width_m = mode10 ? WIDTH10_MASK : WIDTH7_MASK;
    return ((rx ^ own) & mask & width_m) == '0;
  endfunction

endpackage

`default_nettype wire

// [hw/oam_own_addr_match.sv]
/*
  Slave-side own-address recognition: three address slots, general call
  enable, address mask, received-address capture and general call status.
  Assumes a link front end on lnk_clk_i that reports START conditions and
  completed address phases as one-cycle pulses, and a register master on
  mclk_i using the plain strobe port with read data one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - With the general call enable set the device acknowledges a general call; otherwise only a matching slot acknowledges it, and the status flag still sets.
// - Slot zero takes part in matching only while its enable bit is one.
// - Slot one takes part in matching only while its enable bit is one.
// - Slot two takes part in matching only while its enable bit is one.
// - Each slot holds a ten-bit address right justified from bit zero.
// - In seven-bit mode bit six is the top compared bit and bits nine to seven are ignored.
// - In ten-bit mode the whole field is compared with bit nine as top bit.
// - A cleared mask bit makes that address bit a don't care, and the mask resets to all ones.
// - The last received slave address is captured in a readable ten-bit register.
// - A status flag is set on a general call and cleared automatically on START.
module oam_own_addr_match
  import oam_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           resetn_i,
  input  wire logic [AW-1:0]  addr_i,
  input  wire logic [DW-1:0]  wdata_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  output logic      [DW-1:0]  rdata_o,
  input  wire logic           lnk_clk_i,
  input  wire logic           lnk_start_i,
  input  wire logic           lnk_addr_stb_i,
  input  wire logic [AFW-1:0] lnk_addr_i,
  output logic                lnk_ack_o,
  output logic                lnk_ack_valid_o
);

  // Configuration, mclk domain
  logic                 hold_q;
  logic                 mode10_q;
  logic                 gcen_q;
  logic [NSLOT-1:0]     oaen_q;
  logic [AFW-1:0]       oa_q [NSLOT];
  logic [AFW-1:0]       mask_q;
  logic [AFW-1:0]       rxaddr_q;
  logic                 gc_seen_q;

  // Link domain
  logic                 hold_l1_q;
  logic                 hold_l2_q;
  logic [AFW-1:0]       rx_l_q;
  logic                 gc_l_q;
  logic                 addr_tgl_q;
  logic                 start_tgl_q;
  logic [NSLOT-1:0]     slot_hit;
  logic                 gc_hit;
  logic                 ack_d;

  // Back in mclk domain
  logic [2:0]           addr_sync_q;
  logic [2:0]           start_sync_q;
  logic                 addr_evt;
  logic                 start_evt;

  logic                 cfg_wr;

  // Config writes only land while held, so the link side sees static words
  assign cfg_wr = wr_i && hold_q;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      hold_q   <= HOLD_RST;
      mode10_q <= MODE_RST;
    end else if (wr_i && addr_i == OFS_CTRL) begin
      hold_q   <= wdata_i[CTRL_HOLD_BIT];
      mode10_q <= hold_q ? wdata_i[CTRL_MODE_BIT] : mode10_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      gcen_q <= 1'b0;
      oaen_q <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        oa_q[i] <= SLOT_ADDR_RST;
      end
    end else if (cfg_wr) begin
      for (int i = 0; i < NSLOT; i++) begin
        if (addr_i == OFS_SLOT0 + AW'(i)) begin
          oaen_q[i] <= wdata_i[OAEN_BIT];
          oa_q[i]   <= wdata_i[ADDR_MSB:0];
        end
      end
      if (addr_i == OFS_SLOT0) begin
        gcen_q <= wdata_i[GCEN_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      mask_q <= MASK_RST;
    end else if (cfg_wr && addr_i == OFS_MASK) begin
      mask_q <= wdata_i[ADDR_MSB:0];
    end
  end

  // Read port: data only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || !rd_i) begin
      rdata_o <= '0;
    end else begin
      unique case (addr_i)
        OFS_SLOT0:  rdata_o <= {gcen_q, 4'h0, oaen_q[0], oa_q[0]};
        OFS_SLOT1:  rdata_o <= {5'h00, oaen_q[1], oa_q[1]};
        OFS_SLOT2:  rdata_o <= {5'h00, oaen_q[2], oa_q[2]};
        OFS_MASK:   rdata_o <= {6'h00, mask_q};
        OFS_RXADDR: rdata_o <= {6'h00, rxaddr_q};
        OFS_STAT:   rdata_o <= DW'({gc_seen_q, 5'h00});
        OFS_CTRL:   rdata_o <= {14'h0000, mode10_q, hold_q};
        default:    rdata_o <= '0;
      endcase
    end
  end

  // Hold level into link clock; it also qualifies the static config words
  always_ff @(posedge lnk_clk_i) begin
    hold_l1_q <= hold_q;
    hold_l2_q <= hold_l1_q;
  end

  always_comb begin
    for (int i = 0; i < NSLOT; i++) begin
      slot_hit[i] = oaen_q[i] && addr_hit(lnk_addr_i, oa_q[i], mask_q, mode10_q);
    end
    gc_hit = gcen_q && lnk_addr_i == GC_ADDR;
    ack_d  = (|slot_hit) || gc_hit;
  end

  always_ff @(posedge lnk_clk_i) begin
    if (hold_l2_q) begin
      lnk_ack_o       <= 1'b0;
      lnk_ack_valid_o <= 1'b0;
      rx_l_q          <= '0;
      gc_l_q          <= 1'b0;
      addr_tgl_q      <= 1'b0;
    end else begin
      lnk_ack_valid_o <= lnk_addr_stb_i;
      if (lnk_addr_stb_i) begin
        lnk_ack_o  <= ack_d;
        rx_l_q     <= lnk_addr_i;
        gc_l_q     <= lnk_addr_i == GC_ADDR;
        addr_tgl_q <= ~addr_tgl_q;
      end
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (hold_l2_q) begin
      start_tgl_q <= 1'b0;
    end else if (lnk_start_i) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // Toggle crossings; rx_l_q stays put until the next address phase
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      addr_sync_q  <= '0;
      start_sync_q <= '0;
    end else begin
      addr_sync_q  <= {addr_sync_q[1:0], addr_tgl_q};
      start_sync_q <= {start_sync_q[1:0], start_tgl_q};
    end
  end

  assign addr_evt  = addr_sync_q[2] ^ addr_sync_q[1];
  assign start_evt = start_sync_q[2] ^ start_sync_q[1];

  always_ff @(posedge mclk_i) begin
    if (!resetn_i || hold_q) begin
      rxaddr_q <= '0;
    end else if (addr_evt) begin
      rxaddr_q <= rx_l_q;
    end
  end

  // Set beats the START clear if both land together
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || hold_q) begin
      gc_seen_q <= 1'b0;
    end else if (addr_evt && gc_l_q) begin
      gc_seen_q <= 1'b1;
    end else if (start_evt) begin
      gc_seen_q <= 1'b0;
    end
  end

  property p_gc_answer;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && gcen_q && lnk_addr_i == GC_ADDR |=> lnk_ack_o && lnk_ack_valid_o;
  endproperty
  a_gc_answer: assert property (p_gc_answer) else $error("general call not acknowledged");

  property p_gc_ignored;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && !gcen_q && lnk_addr_i == GC_ADDR && slot_hit == '0 |=> !lnk_ack_o;
  endproperty
  a_gc_ignored: assert property (p_gc_ignored) else $error("general call acknowledged while disabled");

  property p_slot0_off;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && !oaen_q[0] && slot_hit[2:1] == 2'b00 && !gc_hit |=> !lnk_ack_o;
  endproperty
  a_slot0_off: assert property (p_slot0_off) else $error("disabled slot zero still matched");

  property p_slot1_on;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && oaen_q[1] && lnk_addr_i == oa_q[1] |=> lnk_ack_o;
  endproperty
  a_slot1_on: assert property (p_slot1_on) else $error("slot one address not acknowledged");

  property p_slot2_on;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && oaen_q[2] && lnk_addr_i == oa_q[2] |=> lnk_ack_o;
  endproperty
  a_slot2_on: assert property (p_slot2_on) else $error("slot two address not acknowledged");

  property p_width7;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && !mode10_q && oaen_q[0] && lnk_addr_i[ADDR7_MSB:0] == oa_q[0][ADDR7_MSB:0] |=> lnk_ack_o;
  endproperty
  a_width7: assert property (p_width7) else $error("seven-bit compare looked at upper bits");

  property p_width10;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && mode10_q && mask_q[ADDR_MSB] && !gc_hit && slot_hit[2:1] == 2'b00
      && lnk_addr_i[ADDR_MSB] != oa_q[0][ADDR_MSB] |=> !lnk_ack_o;
  endproperty
  a_width10: assert property (p_width10) else $error("ten-bit compare ignored top bit");

  property p_mask_dc;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && mode10_q && oaen_q[0] && ((lnk_addr_i ^ oa_q[0]) & mask_q) == '0 |=> lnk_ack_o;
  endproperty
  a_mask_dc: assert property (p_mask_dc) else $error("masked bit was still compared");

  property p_ack_timing;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i |=> lnk_ack_valid_o ##1 !lnk_ack_valid_o || $past(lnk_addr_stb_i);
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("answer strobe not one cycle after address");

  property p_capture;
    @(posedge mclk_i) disable iff (!resetn_i || hold_q)
    addr_evt |=> rxaddr_q == $past(rx_l_q);
  endproperty
  a_capture: assert property (p_capture) else $error("received address not captured");

  property p_gc_clear;
    @(posedge mclk_i) disable iff (!resetn_i || hold_q)
    start_evt && !(addr_evt && gc_l_q) |=> !gc_seen_q;
  endproperty
  a_gc_clear: assert property (p_gc_clear) else $error("general call flag survived START");

  property p_cfg_frozen;
    @(posedge mclk_i) disable iff (!resetn_i)
    !hold_q && wr_i && addr_i == OFS_SLOT0 |=> $stable(oa_q[0]) && $stable(oaen_q[0]) && $stable(gcen_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("slot zero changed outside hold");

  // Link-side checks stay quiet while the synced hold keeps the link logic cleared
  property p_slot0_on;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && oaen_q[0] && lnk_addr_i == oa_q[0] |=> lnk_ack_o;
  endproperty
  a_slot0_on: assert property (p_slot0_on) else $error("slot zero address not acknowledged");

  property p_slot1_off;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && !oaen_q[1] && slot_hit[0] == 1'b0 && slot_hit[2] == 1'b0 && !gc_hit |=> !lnk_ack_o;
  endproperty
  a_slot1_off: assert property (p_slot1_off) else $error("disabled slot one still matched");

  property p_slot2_off;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && !oaen_q[2] && slot_hit[1:0] == 2'b00 && !gc_hit |=> !lnk_ack_o;
  endproperty
  a_slot2_off: assert property (p_slot2_off) else $error("disabled slot two still matched");

  property p_width7_miss;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    lnk_addr_stb_i && !mode10_q && oaen_q[0] && mask_q == MASK_RST && slot_hit[2:1] == 2'b00 && !gc_hit
      && lnk_addr_i[ADDR7_MSB:0] != oa_q[0][ADDR7_MSB:0] |=> !lnk_ack_o;
  endproperty
  a_width7_miss: assert property (p_width7_miss) else $error("seven-bit compare skipped a low bit");

  property p_ack_hold;
    @(posedge lnk_clk_i) disable iff (hold_l2_q)
    !lnk_addr_stb_i && !lnk_ack_valid_o |=> $stable(lnk_ack_o);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("answer changed without a new address");

  // Register-side checks
  property p_mode_hold;
    @(posedge mclk_i) disable iff (!resetn_i)
    !hold_q |=> $stable(mode10_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("addressing width changed outside hold");

  property p_rx_read;
    @(posedge mclk_i) disable iff (!resetn_i)
    rd_i && addr_i == OFS_RXADDR |=> rdata_o[AFW-1:0] == $past(rxaddr_q) && rdata_o[DW-1:AFW] == '0;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("received address read back wrong");

  property p_slot_rd;
    @(posedge mclk_i) disable iff (!resetn_i)
    rd_i && addr_i == OFS_SLOT1 |=> rdata_o[ADDR_MSB:0] == $past(oa_q[1])
      && rdata_o[OAEN_BIT] == $past(oaen_q[1]);
  endproperty
  a_slot_rd: assert property (p_slot_rd) else $error("slot one field not right justified");

  property p_gc_set;
    @(posedge mclk_i) disable iff (!resetn_i || hold_q)
    addr_evt && gc_l_q |=> gc_seen_q;
  endproperty
  a_gc_set: assert property (p_gc_set) else $error("general call flag not set");

  c_gc_ack:   cover property (@(posedge lnk_clk_i) disable iff (hold_l2_q) lnk_addr_stb_i && gc_hit);
  c_w7_ack:   cover property (@(posedge lnk_clk_i) disable iff (hold_l2_q)
                              lnk_addr_stb_i && !mode10_q && |slot_hit);
  c_mask_ack: cover property (@(posedge lnk_clk_i) disable iff (hold_l2_q)
                              lnk_addr_stb_i && mask_q != MASK_RST && |slot_hit);
  c_gc_flag:  cover property (@(posedge mclk_i) disable iff (!resetn_i) $rose(gc_seen_q));
  c_gc_clr:   cover property (@(posedge mclk_i) disable iff (!resetn_i) $fell(gc_seen_q));

endmodule

`default_nettype wire

// [verif/oam_lnk_master.sv]
/*
  Link-side master model: sends START and address phases to the own-address
  block and reports the acknowledge it gets back.
  Assumes one caller at a time and no other driver of the link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module oam_lnk_master
  import oam_pkg::*;
(
  output logic           lnk_clk_o,
  output logic           lnk_start_o,
  output logic           lnk_addr_stb_o,
  output logic [AFW-1:0] lnk_addr_o,
  input  wire logic      lnk_ack_i,
  input  wire logic      lnk_ack_valid_i
);
  initial begin
    lnk_clk_o = 1'b0;
    lnk_start_o = 1'b0;
    lnk_addr_stb_o = 1'b0;
    lnk_addr_o = '0;
  end
  // Clock stands still between frames
  task automatic tick(input int n);
    repeat (n) begin
      #24 lnk_clk_o = 1'b1;
      #24 lnk_clk_o = 1'b0;
    end
  endtask
  task automatic pulse(input logic stb, input logic [AFW-1:0] a);
    #24 lnk_clk_o = 1'b1;
    lnk_start_o <= !stb;
    lnk_addr_stb_o <= stb;
    lnk_addr_o <= a;
    #24 lnk_clk_o = 1'b0;
    #24 lnk_clk_o = 1'b1;
    lnk_start_o <= 1'b0;
    lnk_addr_stb_o <= 1'b0;
    // Released bus must not keep showing the address
    lnk_addr_o <= ~a;
    #24 lnk_clk_o = 1'b0;
  endtask
  task automatic frame(input logic [AFW-1:0] a, output logic ack, output logic vld);
    tick(4);
    pulse(1'b0, a);
    pulse(1'b1, a);
    ack = lnk_ack_i;
    vld = lnk_ack_valid_i;
    tick(1);
    vld = vld & !lnk_ack_valid_i;
    tick(4);
  endtask
  task automatic start_only();
    tick(4);
    pulse(1'b0, '0);
    tick(2);
  endtask
endmodule
`default_nettype wire

// [verif/oam_own_addr_match_tb_top.sv]
/*
  Self-checking bench for the own-address block: register port on mclk,
  link traffic from the master model on its own clock.
  Assumes the register map and reset values of oam_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module oam_own_addr_match_tb_top
  import oam_pkg::*;
;
  logic           mclk;
  logic           resetn;
  logic [AW-1:0]  addr;
  logic [DW-1:0]  wdata;
  logic           wr;
  logic           rd;
  logic [DW-1:0]  rdata;
  logic           lclk;
  logic           lstart;
  logic           lstb;
  logic [AFW-1:0] laddr;
  logic           lack;
  logic           lvld;
  int             errors;
  int             samples_checked;

  oam_own_addr_match i_dut (.mclk_i(mclk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .lnk_clk_i(lclk), .lnk_start_i(lstart),
    .lnk_addr_stb_i(lstb), .lnk_addr_i(laddr), .lnk_ack_o(lack), .lnk_ack_valid_o(lvld));
  oam_lnk_master i_mst (.lnk_clk_o(lclk), .lnk_start_o(lstart), .lnk_addr_stb_o(lstb),
    .lnk_addr_o(laddr), .lnk_ack_i(lack), .lnk_ack_valid_i(lvld));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check($sformatf("reg_%h", a), rdata, exp);
  endtask
  task automatic link(input logic [AFW-1:0] a, input logic ea, input logic ev);
    logic ack;
    logic v;
    i_mst.frame(a, ack, v);
    check("ack_valid", {15'h0000, v}, {15'h0000, ev});
    if (ev) begin
      check("ack", {15'h0000, ack}, {15'h0000, ea});
    end
    // Capture needs a few mclk cycles to cross
    repeat (4) @(posedge mclk);
  endtask

  task automatic t_reset();
    rchk(OFS_SLOT0, 16'h0000);
    rchk(OFS_SLOT1, 16'h0000);
    rchk(OFS_SLOT2, 16'h0000);
    rchk(OFS_MASK, 16'h03ff);
    rchk(OFS_RXADDR, 16'h0000);
    rchk(OFS_STAT, 16'h0000);
    rchk(OFS_CTRL, 16'h0001);
    rchk(4'hf, 16'h0000);
  endtask
  task automatic t_seven();
    wr_reg(OFS_SLOT0, 16'h87d5);
    wr_reg(OFS_SLOT1, 16'h0792);
    wr_reg(OFS_SLOT2, 16'h0033);
    rchk(OFS_SLOT1, 16'h0792);
    wr_reg(OFS_CTRL, 16'h0000);
    link(10'h055, 1'b1, 1'b1);
    link(10'h012, 1'b1, 1'b1);
    link(10'h033, 1'b0, 1'b1);
    link(10'h056, 1'b0, 1'b1);
    rchk(OFS_RXADDR, 16'h0056);
    link(10'h000, 1'b1, 1'b1);
    rchk(OFS_STAT, 16'h0020);
    i_mst.start_only();
    repeat (4) @(posedge mclk);
    rchk(OFS_STAT, 16'h0000);
    // Outside hold the write must be dropped
    wr_reg(OFS_SLOT0, 16'h0000);
    rchk(OFS_SLOT0, 16'h87d5);
  endtask
  task automatic t_ten();
    wr_reg(OFS_CTRL, 16'h0003);
    link(10'h233, 1'b0, 1'b0);
    wr_reg(OFS_SLOT0, 16'h0455);
    wr_reg(OFS_SLOT2, 16'h0633);
    wr_reg(OFS_MASK, 16'h03fc);
    rchk(OFS_SLOT2, 16'h0633);
    wr_reg(OFS_CTRL, 16'h0002);
    link(10'h233, 1'b1, 1'b1);
    link(10'h033, 1'b0, 1'b1);
    link(10'h057, 1'b1, 1'b1);
    link(10'h000, 1'b0, 1'b1);
    link(10'h055, 1'b1, 1'b1);
    link(10'h392, 1'b1, 1'b1);
    link(10'h255, 1'b0, 1'b1);
    // Mode bit must be refused while the hold is being set
    wr_reg(OFS_CTRL, 16'h0001);
    rchk(OFS_CTRL, 16'h0003);
    rchk(OFS_RXADDR, 16'h0000);
    wr_reg(OFS_SLOT0, 16'h0055);
    wr_reg(OFS_SLOT1, 16'h0392);
    wr_reg(OFS_CTRL, 16'h0002);
    link(10'h055, 1'b0, 1'b1);
    link(10'h392, 1'b0, 1'b1);
    link(10'h233, 1'b1, 1'b1);
  endtask

  initial begin
    errors = 0;
    samples_checked = 0;
    resetn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    i_mst.tick(3);
    t_reset();
    t_seven();
    t_ten();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
